/* rtl/cta_low_pick.sv */
// Keeps only the lowest-numbered set bit of a select vector
`timescale 1ns/1ps
`default_nettype none
module cta_low_pick (
	// Select vector
	input wire logic [cta_pkg::NBUF-1:0] vec,
	// One-hot result, zero when nothing is set
	output logic [cta_pkg::NBUF-1:0] onehot
);
	import cta_pkg::*;

	logic [NBUF:0] below;

	assign below[0] = 1'b0;
	generate
		for (genvar i = 0; i < NBUF; i++) begin : g_bit
			assign below[i+1] = below[i] | vec[i];
			assign onehot[i] = vec[i] & ~below[i];
		end
	endgenerate
endmodule
`default_nettype wire

/* rtl/cta_sync2.sv */
// Two-flop synchroniser for a level arriving from outside the clock domain
`timescale 1ns/1ps
`default_nettype none
module cta_sync2 (
	// Clocking
	input wire logic clk,
	input wire logic rst_n,
	input wire logic ce,
	// Level
	input wire logic async_in,
	output logic sync_out
);
	logic stage1;

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			stage1 <= 1'b0;
			sync_out <= 1'b0;
		end else if (ce) begin
			stage1 <= async_in;
			sync_out <= stage1;
		end
	end
endmodule
`default_nettype wire

/* rtl/cta_top.sv */
// Transmit abort acknowledge, buffer select and acceptance filter control with APB access
//
// Operation
// - Abort acknowledge readable always, writes ignored
// - Abort acknowledge held reset during initialization
// - Abort done set only on granted abort
// - Clearing free flag clears abort done
// - Select read shows lowest set bit only
// - Select held reset in init, written only when neither handshake bit is set
// - Lowest set select bit picks the buffer
// - Window blocked for selected scheduled buffer
// - No selection refuses every window access
// - Filter control written only in init
// - Mode field picks filter layout or closed
// - Closed filter accepts no received message
// - Hit field gives matching filter number
// - Hit field follows foreground buffer message
// - Test register reads zero outside test mode
// - Granted abort sets free flag, clears request
// - Sent message sets free flag; software clears
`timescale 1ns/1ps
`default_nettype none
module cta_top (
	// Clocking
	input wire logic clk,
	input wire logic rst_n,
	input wire logic ce,
	// APB slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [cta_pkg::ADDR_W-1:0] paddr,
	input wire logic [cta_pkg::DATA_W-1:0] pwdata,
	output logic [cta_pkg::DATA_W-1:0] prdata,
	output logic pready,
	output logic pslverr,
	// Controller mode handshake
	input wire logic init_request,
	input wire logic init_ack,
	// Transmitter events, one-cycle pulses per buffer
	input wire logic [cta_pkg::NBUF-1:0] tx_sent,
	input wire logic [cta_pkg::NBUF-1:0] tx_abort_grant,
	// Receiver foreground buffer load
	input wire logic rx_shift,
	input wire logic [cta_pkg::HIT_W-1:0] rx_hit,
	// Special test mode pin
	input wire logic test_mode_pin,
	// Transmitter side status
	output logic [cta_pkg::NBUF-1:0] send_slot_free_flag,
	output logic [cta_pkg::NBUF-1:0] abort_request_bit,
	output logic [cta_pkg::NBUF-1:0] window_sel,
	output logic window_open,
	// Filter side status
	output logic [cta_pkg::FMODE_W-1:0] filter_mode_field,
	output logic filter_closed,
	output logic rx_accept,
	// Interrupt
	output logic irq
);
	import cta_pkg::*;

	////////////////////////////////////////////////////////////////////////////
	// Declarations
	logic init_mode;
	logic run_mode;
	logic test_mode;
	logic setup_ph;
	logic access_ph;
	logic wr_en;
	logic rd_done;
	logic [IDX_W-1:0] idx;
	logic addr_ok;
	logic hit_sel;
	logic [BYTE_W-1:0] wbyte;
	logic [NBUF-1:0] abort_done_flag;
	logic [NBUF-1:0] picker;
	logic [NBUF-1:0] picker_low;
	logic [HIT_W-1:0] filter_hit_field;
	logic [BYTE_W-1:0] test_scratch;
	logic [IRQ_W-1:0] irq_status;
	logic [IRQ_W-1:0] irq_mask;
	logic [IRQ_W-1:0] irq_events;
	logic [IRQ_W-1:0] irq_reported;
	logic [NBUF-1:0] sent_ok;
	logic [NBUF-1:0] abort_ok;
	logic [NBUF-1:0] free_set;
	logic [NBUF-1:0] free_clr;
	logic [NBUF-1:0] next_free;
	logic [NBUF-1:0] next_picker_low;
	logic rx_take;
	logic [BYTE_W-1:0] next_rbyte;
	logic next_err;

	////////////////////////////////////////////////////////////////////////////
	// Mode decode
	// Both handshake bits from controller logic on this clock, so no synchroniser
	assign init_mode = init_request & init_ack;
	assign run_mode = ~init_request & ~init_ack;

	cta_sync2 u_test_sync (
		.clk(clk),
		.rst_n(rst_n),
		.ce(ce),
		.async_in(test_mode_pin),
		.sync_out(test_mode)
	);

	////////////////////////////////////////////////////////////////////////////
	// APB decode
	assign idx = paddr[IDX_LSB +: IDX_W];
	assign setup_ph = psel & ~penable;
	assign access_ph = psel & penable & pready;
	assign wr_en = access_ph & pwrite & ~pslverr;
	assign rd_done = access_ph & ~pwrite & ~pslverr;
	assign wbyte = pwdata[BYTE_W-1:0];
	assign hit_sel = (paddr[IDX_LSB-1:0] == '0) && (paddr[ADDR_W-1:IDX_LSB+IDX_W] == '0);

	always_comb begin
		case (idx)
			IDX_SEND_FLAG,
			IDX_ABORT_REQ,
			IDX_ABORT_ACK,
			IDX_PICKER,
			IDX_FLT_CTRL,
			IDX_FACTORY_TEST,
			IDX_IRQ_STATUS,
			IDX_IRQ_MASK: addr_ok = hit_sel;
			default: addr_ok = 1'b0;
		endcase
	end

	// Read data built in the setup cycle and registered for the access cycle
	always_comb begin
		next_rbyte = '0;
		next_err = ~addr_ok;
		case (idx)
			IDX_SEND_FLAG: next_rbyte[NBUF-1:0] = send_slot_free_flag;
			IDX_ABORT_REQ: next_rbyte[NBUF-1:0] = abort_request_bit;
			IDX_ABORT_ACK: next_rbyte[NBUF-1:0] = abort_done_flag;
			IDX_PICKER: next_rbyte[NBUF-1:0] = picker_low;
			IDX_FLT_CTRL: begin
				next_rbyte[FMODE_LSB +: FMODE_W] = filter_mode_field;
				next_rbyte[HIT_LSB +: HIT_W] = filter_hit_field;
			end
			IDX_FACTORY_TEST: next_rbyte = test_mode ? test_scratch : RST_TEST;
			IDX_IRQ_STATUS: next_rbyte[IRQ_W-1:0] = irq_status;
			IDX_IRQ_MASK: next_rbyte[IRQ_W-1:0] = irq_mask;
			default: next_rbyte = '0;
		endcase
	end

	// One wait-free answer: pready rises in the first access cycle
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			pready <= 1'b0;
			pslverr <= 1'b0;
			prdata <= RST_DATA;
		end else if (ce) begin
			if (setup_ph) begin
				pready <= 1'b1;
				pslverr <= next_err;
				prdata <= pwrite ? RST_DATA : {{(DATA_W-BYTE_W){1'b0}}, next_rbyte};
			end else begin
				pready <= 1'b0;
				pslverr <= 1'b0;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Transmit free flags
	// Events only count for a buffer that is actually scheduled
	assign sent_ok = tx_sent & ~send_slot_free_flag;
	assign abort_ok = tx_abort_grant & abort_request_bit & ~send_slot_free_flag & ~tx_sent;
	assign free_set = sent_ok | abort_ok;
	assign free_clr = (wr_en && idx == IDX_SEND_FLAG && run_mode) ?
		(wbyte[NBUF-1:0] & send_slot_free_flag) : RST_NBUF_ZERO;
	// Set beats clear, though a clear only hits a flag already set
	assign next_free = (send_slot_free_flag & ~free_clr) | free_set;

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			send_slot_free_flag <= RST_SEND_FREE;
		end else if (ce) begin
			send_slot_free_flag <= next_free;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Abort requests: software can set, a set free flag or init mode clears
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			abort_request_bit <= RST_NBUF_ZERO;
		end else if (ce) begin
			if (init_mode) begin
				abort_request_bit <= RST_NBUF_ZERO;
			end else if (wr_en && idx == IDX_ABORT_REQ && run_mode) begin
				abort_request_bit <= (abort_request_bit | wbyte[NBUF-1:0]) & ~next_free;
			end else begin
				abort_request_bit <= abort_request_bit & ~next_free;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Abort acknowledge; no write path exists for it
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			abort_done_flag <= RST_NBUF_ZERO;
		end else if (ce) begin
			if (init_mode) begin
				abort_done_flag <= RST_NBUF_ZERO;
			end else begin
				// A normal send never sets it, so software can tell the outcomes apart
				abort_done_flag <= (abort_done_flag & ~free_clr) | abort_ok;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Transmit buffer select
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			picker <= RST_NBUF_ZERO;
		end else if (ce) begin
			if (init_mode) begin
				picker <= RST_NBUF_ZERO;
			end else if (wr_en && idx == IDX_PICKER && run_mode) begin
				// Zero write leaves nothing selected until a later write
				picker <= wbyte[NBUF-1:0];
			end
		end
	end

	cta_low_pick u_pick_now (
		.vec(picker),
		.onehot(picker_low)
	);

	// Window decode follows the picker one cycle later
	cta_low_pick u_pick_next (
		.vec(init_mode ? RST_NBUF_ZERO : picker),
		.onehot(next_picker_low)
	);

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			window_sel <= RST_NBUF_ZERO;
			window_open <= 1'b0;
		end else if (ce) begin
			window_sel <= next_picker_low;
			// Closed when nothing selected, or the selection is still queued
			window_open <= |(next_picker_low & next_free);
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Acceptance filter control
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			filter_mode_field <= RST_FMODE;
			filter_closed <= 1'b0;
		end else if (ce) begin
			if (wr_en && idx == IDX_FLT_CTRL && init_mode) begin
				// Hit bits of the written byte are dropped
				filter_mode_field <= wbyte[FMODE_LSB +: FMODE_W];
				filter_closed <= (wbyte[FMODE_LSB +: FMODE_W] == FMODE_CLOSED);
			end
		end
	end

	// Closed filter blocks any foreground reload
	assign rx_take = rx_shift & ~filter_closed;

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			rx_accept <= 1'b0;
		end else if (ce) begin
			rx_accept <= rx_take;
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			filter_hit_field <= RST_HIT;
		end else if (ce) begin
			if (rx_take) begin
				filter_hit_field <= rx_hit;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Factory test register, a scratch byte only reachable in test mode
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			test_scratch <= RST_TEST;
		end else if (ce) begin
			if (wr_en && idx == IDX_FACTORY_TEST && test_mode) begin
				test_scratch <= wbyte;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Interrupts
	assign irq_events[IRQ_FREE_LSB +: NBUF] = free_set;
	assign irq_events[IRQ_ABORT_BIT] = |abort_ok;
	assign irq_events[IRQ_RXHIT_BIT] = rx_take;

	// Only bits that the read returned are cleared, so a later event survives
	assign irq_reported = (rd_done && idx == IDX_IRQ_STATUS) ? prdata[IRQ_W-1:0] : RST_IRQ;

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			irq_status <= RST_IRQ;
		end else if (ce) begin
			irq_status <= (irq_status & ~irq_reported) | irq_events;
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			irq_mask <= RST_IRQ;
		end else if (ce) begin
			if (wr_en && idx == IDX_IRQ_MASK) begin
				irq_mask <= wbyte[IRQ_W-1:0];
			end
		end
	end

	// Registered, so it trails the status bit by one cycle
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			irq <= 1'b0;
		end else if (ce) begin
			irq <= |(irq_status & irq_mask);
		end
	end

endmodule
`default_nettype wire

/* shared/cta_pkg.sv */
// Constants shared by the transmit abort, buffer select and filter control block
package cta_pkg;

	////////////////////////////////////////////////////////////////////////////
	// Bus geometry
	localparam int ADDR_W = 12;
	localparam int DATA_W = 32;
	localparam int IDX_W = 8;
	localparam int IDX_LSB = 2;
	localparam int BYTE_W = 8;

	////////////////////////////////////////////////////////////////////////////
	// Register indices; byte address is four times the index
	localparam logic [IDX_W-1:0] IDX_SEND_FLAG = 8'h06;
	localparam logic [IDX_W-1:0] IDX_ABORT_REQ = 8'h08;
	localparam logic [IDX_W-1:0] IDX_ABORT_ACK = 8'h09;
	localparam logic [IDX_W-1:0] IDX_PICKER = 8'h0a;
	localparam logic [IDX_W-1:0] IDX_FLT_CTRL = 8'h0b;
	localparam logic [IDX_W-1:0] IDX_FACTORY_TEST = 8'h0c;
	localparam logic [IDX_W-1:0] IDX_IRQ_STATUS = 8'h20;
	localparam logic [IDX_W-1:0] IDX_IRQ_MASK = 8'h21;

	////////////////////////////////////////////////////////////////////////////
	// Field layout
	localparam int NBUF = 3;
	localparam int FMODE_LSB = 4;
	localparam int FMODE_W = 2;
	localparam int HIT_LSB = 0;
	localparam int HIT_W = 3;
	localparam logic [FMODE_W-1:0] FMODE_CLOSED = 2'h3;

	// Interrupt status bits: one per buffer free event, abort done, receive hit
	localparam int IRQ_W = 5;
	localparam int IRQ_FREE_LSB = 0;
	localparam int IRQ_ABORT_BIT = 3;
	localparam int IRQ_RXHIT_BIT = 4;

	////////////////////////////////////////////////////////////////////////////
	// Reset values
	localparam logic [NBUF-1:0] RST_SEND_FREE = 3'h7;
	localparam logic [NBUF-1:0] RST_NBUF_ZERO = 3'h0;
	localparam logic [FMODE_W-1:0] RST_FMODE = 2'h0;
	localparam logic [HIT_W-1:0] RST_HIT = 3'h0;
	localparam logic [BYTE_W-1:0] RST_TEST = 8'h00;
	localparam logic [IRQ_W-1:0] RST_IRQ = 5'h00;
	localparam logic [DATA_W-1:0] RST_DATA = 32'h0000_0000;

endpackage

/* tb/cta_cpu_model.sv */
// CPU model issuing APB register transfers
`timescale 1ns/1ps
`default_nettype none
module cta_cpu_model (
	// Clock
	input wire logic clk,
	// APB master
	output logic psel,
	output logic penable,
	output logic pwrite,
	output logic [11:0] paddr,
	output logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr
);
	initial begin
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 12'h000;
		pwdata = 32'h0000_0000;
	end
	// Request held until ready seen at an edge
	task automatic xfer(input logic w, input logic [7:0] idx, input logic [31:0] d, output logic [31:0] q,
		output logic e);
		int n;
		@(posedge clk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= {2'b00, idx, 2'b00};
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge clk);
			n++;
		end while (pready !== 1'b1 && n < 16);
		q = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		pwdata <= ~d;
		if (n == 16) begin
			$display("BAD t=%0t pready got=%h exp=%h", $time, pready, 1'b1);
			tb_top.mismatches++;
			tb_top.final_report();
		end
	endtask
endmodule
`default_nettype wire

/* tb/cta_top_sva.sv */
// Assertion checker for the abort, buffer select and filter control block
`timescale 1ns/1ps
`default_nettype none
module cta_top_sva (
	// Clocking
	input wire logic clk,
	input wire logic rst_n,
	input wire logic ce,
	// Controller events
	input wire logic init_request,
	input wire logic init_ack,
	input wire logic [2:0] tx_sent,
	input wire logic [2:0] tx_abort_grant,
	input wire logic rx_shift,
	// Status outputs
	input wire logic [2:0] send_slot_free_flag,
	input wire logic [2:0] abort_request_bit,
	input wire logic [2:0] window_sel,
	input wire logic window_open,
	input wire logic [1:0] filter_mode_field,
	input wire logic filter_closed,
	input wire logic rx_accept
);
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_n);
	sent_frees_a: assert property (tx_sent[2] && !send_slot_free_flag[2] && ce |=> send_slot_free_flag[2])
		else $error("sent buffer not freed");
	grant_frees_a: assert property (tx_abort_grant[1] && abort_request_bit[1] && !send_slot_free_flag[1]
		&& !tx_sent[1] && ce |=> send_slot_free_flag[1] && !abort_request_bit[1])
		else $error("granted abort not freed");
	free_clears_req_a: assert property ($rose(send_slot_free_flag[2]) |-> !abort_request_bit[2])
		else $error("request kept after free");
	free_cause_a: assert property ($rose(send_slot_free_flag[2]) |-> $past(tx_sent[2] || tx_abort_grant[2]))
		else $error("free flag set without cause");
	init_hold_a: assert property ((init_request && init_ack) [*3] |-> window_sel == 3'h0 && abort_request_bit == 3'h0)
		else $error("select not held in init");
	sel_lowest_a: assert property ($onehot0(window_sel))
		else $error("window select not one-hot");
	// Window and free flags move on the same edge, so compare current values
	open_needs_sel_a: assert property (window_open |-> |(window_sel & send_slot_free_flag))
		else $error("window open on busy or no buffer");
	closed_drops_a: assert property (rx_shift && filter_closed |=> !rx_accept)
		else $error("closed filter accepted");
	open_accepts_a: assert property (rx_shift && !filter_closed && ce |=> rx_accept)
		else $error("open filter dropped");
	mode_locked_a: assert property (!$past(init_request && init_ack) |-> $stable(filter_mode_field))
		else $error("mode changed outside init");
	closed_flag_a: assert property (filter_closed == (filter_mode_field == 2'h3))
		else $error("closed flag wrong");
	cover property (rx_shift && filter_closed);
	cover property (|(tx_abort_grant & abort_request_bit));
	cover property (window_open);
endmodule
bind cta_top cta_top_sva i_cta_top_sva (.*);
`default_nettype wire

/* tb/tb_top.sv */
// Self-checking bench for the abort, buffer select and filter control block
`timescale 1ns/1ps
`default_nettype none
module tb_top;
	import cta_pkg::*;
	logic clk = 1'b0;
	logic rst_n = 1'b0;
	logic psel, penable, pwrite, pready, pslverr, window_open, filter_closed, rx_accept, irq;
	logic init_request = 1'b0, init_ack = 1'b0, rx_shift = 1'b0;
	logic ce = 1'b1, test_mode_pin = 1'b0;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata;
	logic [2:0] tx_sent = 3'h0, tx_abort_grant = 3'h0, rx_hit = 3'h0;
	logic [2:0] send_slot_free_flag, abort_request_bit, window_sel;
	logic [1:0] filter_mode_field;
	int mismatches = 0;
	int checks_done = 0;
	always #5 clk = ~clk;
	cta_top i_cta_top (.*);
	cta_cpu_model i_cta_cpu_model (.*);
	////////////////////////////////////////////////////////////////////////////
	function automatic void chk(input logic [31:0] got, input logic [31:0] exp);
		checks_done++;
		if (got !== exp) begin
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
			mismatches++;
		end
	endfunction
	task automatic rd(input logic [7:0] idx, input logic [31:0] exp);
		logic [31:0] q;
		logic e;
		i_cta_cpu_model.xfer(1'b0, idx, 32'h0000_0000, q, e);
		chk(q, exp);
	endtask
	task automatic wr(input logic [7:0] idx, input logic [31:0] d);
		logic [31:0] q;
		logic e;
		i_cta_cpu_model.xfer(1'b1, idx, d, q, e);
	endtask
	task automatic pulse(input logic [2:0] s, input logic [2:0] g, input logic sh, input logic [2:0] h);
		@(posedge clk);
		tx_sent <= s;
		tx_abort_grant <= g;
		rx_shift <= sh;
		rx_hit <= h;
		@(posedge clk);
		tx_sent <= 3'h0;
		tx_abort_grant <= 3'h0;
		rx_shift <= 1'b0;
		#1;
	endtask
	task automatic setm(input logic v);
		@(posedge clk);
		init_request <= v;
		init_ack <= v;
		repeat (3) @(posedge clk);
	endtask
	task automatic final_report;
		$display("checks %0d mismatches %0d", checks_done, mismatches);
		if (mismatches == 0 && checks_done > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask
	////////////////////////////////////////////////////////////////////////////
	task automatic t_regs;
		logic [31:0] q;
		logic e;
		rd(IDX_SEND_FLAG, 32'h0000_0007);
		wr(IDX_ABORT_ACK, 32'h0000_0007);
		rd(IDX_ABORT_ACK, 32'h0000_0000);
		wr(IDX_FACTORY_TEST, 32'h0000_00ff);
		rd(IDX_FACTORY_TEST, 32'h0000_0000);
		i_cta_cpu_model.xfer(1'b0, 8'h30, 32'h0000_0000, q, e);
		chk({31'h0, e}, 32'h0000_0001);
		$display("regs test done");
	endtask
	task automatic t_pick;
		logic [31:0] q;
		logic e;
		i_cta_cpu_model.xfer(1'b0, IDX_SEND_FLAG, 32'h0000_0000, q, e);
		wr(IDX_PICKER, q);
		rd(IDX_PICKER, 32'h0000_0001);
		chk({31'h0, window_open}, 32'h0000_0001);
		wr(IDX_PICKER, 32'h0000_0006);
		rd(IDX_PICKER, 32'h0000_0002);
		chk({29'h0, window_sel}, 32'h0000_0002);
		wr(IDX_PICKER, 32'h0000_0000);
		rd(IDX_PICKER, 32'h0000_0000);
		chk({31'h0, window_open}, 32'h0000_0000);
		wr(IDX_PICKER, 32'h0000_0004);
		wr(IDX_SEND_FLAG, 32'h0000_0004);
		rd(IDX_SEND_FLAG, 32'h0000_0003);
		chk({28'h0, window_sel, window_open}, 32'h0000_0008);
		$display("select test done");
	endtask
	task automatic t_abort;
		wr(IDX_SEND_FLAG, 32'h0000_0002);
		wr(IDX_IRQ_MASK, 32'h0000_0008);
		wr(IDX_ABORT_REQ, 32'h0000_0006);
		pulse(3'h0, 3'h6, 1'b0, 3'h0);
		rd(IDX_SEND_FLAG, 32'h0000_0007);
		rd(IDX_ABORT_ACK, 32'h0000_0006);
		rd(IDX_ABORT_REQ, 32'h0000_0000);
		chk({31'h0, irq}, 32'h0000_0001);
		rd(IDX_IRQ_STATUS, 32'h0000_000e);
		rd(IDX_IRQ_STATUS, 32'h0000_0000);
		chk({31'h0, irq}, 32'h0000_0000);
		wr(IDX_SEND_FLAG, 32'h0000_0004);
		rd(IDX_ABORT_ACK, 32'h0000_0002);
		wr(IDX_ABORT_REQ, 32'h0000_0004);
		pulse(3'h4, 3'h0, 1'b0, 3'h0);
		rd(IDX_SEND_FLAG, 32'h0000_0007);
		rd(IDX_ABORT_ACK, 32'h0000_0002);
		setm(1'b1);
		rd(IDX_ABORT_ACK, 32'h0000_0000);
		wr(IDX_PICKER, 32'h0000_0001);
		rd(IDX_PICKER, 32'h0000_0000);
		$display("abort test done");
	endtask
	task automatic t_filt;
		// Hit bits written as ones must not stick
		for (int m = 0; m < 4; m++) begin
			wr(IDX_FLT_CTRL, 32'(m << 4) | 32'h0000_0007);
			rd(IDX_FLT_CTRL, 32'(m << 4));
			chk({30'h0, filter_mode_field}, 32'(m));
		end
		setm(1'b0);
		wr(IDX_FLT_CTRL, 32'h0000_0000);
		rd(IDX_FLT_CTRL, 32'h0000_0030);
		pulse(3'h0, 3'h0, 1'b1, 3'h5);
		chk({31'h0, rx_accept}, 32'h0000_0000);
		rd(IDX_FLT_CTRL, 32'h0000_0030);
		setm(1'b1);
		wr(IDX_FLT_CTRL, 32'h0000_0000);
		setm(1'b0);
		for (int h = 2; h < 8; h += 5) begin
			pulse(3'h0, 3'h0, 1'b1, 3'(h));
			chk({31'h0, rx_accept}, 32'h0000_0001);
			rd(IDX_FLT_CTRL, 32'(h));
		end
		$display("filter test done");
	endtask
	task automatic t_modes;
		// Test pin passes a two-flop synchroniser before the scratch opens
		@(posedge clk);
		test_mode_pin <= 1'b1;
		repeat (3) @(posedge clk);
		wr(IDX_FACTORY_TEST, 32'h0000_005a);
		rd(IDX_FACTORY_TEST, 32'h0000_005a);
		@(posedge clk);
		test_mode_pin <= 1'b0;
		repeat (3) @(posedge clk);
		rd(IDX_FACTORY_TEST, 32'h0000_0000);
		// Frozen enable drops a receive pulse and keeps the hit field
		@(posedge clk);
		ce <= 1'b0;
		pulse(3'h0, 3'h0, 1'b1, 3'h3);
		chk({31'h0, rx_accept}, 32'h0000_0000);
		@(posedge clk);
		ce <= 1'b1;
		rd(IDX_FLT_CTRL, 32'h0000_0007);
		$display("mode test done");
	endtask
	////////////////////////////////////////////////////////////////////////////
	initial begin
		repeat (2) @(posedge clk);
		rst_n <= 1'b1;
		t_regs();
		t_pick();
		t_abort();
		t_filt();
		t_modes();
		final_report();
	end
	// Hang guard
	initial begin
		repeat (20000) @(posedge clk);
		$display("BAD t=%0t hang got=%h exp=%h", $time, checks_done, 32'h0000_0000);
		mismatches++;
		final_report();
	end
endmodule
`default_nettype wire
